// *** verilog/swid_pkg.sv ***
/*
 * constants shared by both ends of the single-wire identification link:
 * slot timing in microseconds and derived cycle counts, identity code layout.
 * assumes a 50 MHz clock on every module that uses it.
 */
package swid_pkg;
	localparam int          CLK_MHZ                  = 50;
	localparam int          ROM_BITS                 = 64;
	localparam int          SERIAL_BITS              = 48;
	localparam int          DATA_BITS                = 56;
	localparam int          CRC_BITS                 = 8;
	localparam logic [7:0]  CRC_POLY                 = 8'h8c;
	localparam logic [7:0]  CRC_RESET                = 8'h00;
	// times in microseconds as printed
	localparam int          RESET_LOW_US             = 480;
	localparam int          RESET_LOW_MAX_US         = 960;
	localparam int          POST_RESET_HIGH_US       = 480;
	localparam int          PRESENCE_WAIT_MIN_US     = 15;
	localparam int          PRESENCE_WAIT_MAX_US     = 60;
	localparam int          PRESENCE_LOW_MIN_US      = 60;
	localparam int          PRESENCE_LOW_MAX_US      = 240;
	localparam int          SLOT_SAMPLE_US           = 15;
	localparam int          WRITE_ZERO_LOW_US        = 60;
	localparam int          WRITE_ONE_LOW_US         = 1;
	localparam int          READ_LOW_US              = 1;
	localparam int          RECOVERY_US              = 1;
	localparam int          SLOT_US                  = 61;
	localparam int          SLAVE_SAMPLE_US          = 30;
	localparam int          PRESENCE_WAIT_US         = 30;
	localparam int          PRESENCE_LOW_US          = 120;
	localparam int          MSP_US                   = 70;
	// cycle counts; least times round up (whole us, so exact)
	localparam int          RESET_LOW_CYC            = RESET_LOW_US * CLK_MHZ;
	localparam int          RESET_MAX_CYC            = RESET_LOW_MAX_US * CLK_MHZ;
	localparam int          POST_RESET_HIGH_CYC      = POST_RESET_HIGH_US * CLK_MHZ;
	localparam int          PRESENCE_WAIT_CYC        = PRESENCE_WAIT_US * CLK_MHZ;
	localparam int          PRESENCE_LOW_CYC         = PRESENCE_LOW_US * CLK_MHZ;
	localparam int          SLAVE_SAMPLE_CYC         = SLAVE_SAMPLE_US * CLK_MHZ;
	localparam int          READ_HOLD_CYC            = SLOT_SAMPLE_US * CLK_MHZ;
	localparam int          WRITE_ZERO_LOW_CYC       = WRITE_ZERO_LOW_US * CLK_MHZ;
	localparam int          WRITE_ONE_LOW_CYC        = WRITE_ONE_LOW_US * CLK_MHZ;
	localparam int          READ_LOW_CYC             = READ_LOW_US * CLK_MHZ;
	localparam int          MASTER_SAMPLE_CYC        = (SLOT_SAMPLE_US * CLK_MHZ) - 50;
	localparam int          SLOT_CYC                 = SLOT_US * CLK_MHZ;
	localparam int          RECOVERY_CYC             = RECOVERY_US * CLK_MHZ;
	localparam int          MSP_CYC                  = MSP_US * CLK_MHZ;
	localparam int          CNT_W                    = 16;
	localparam int          FIFO_DEPTH               = 8;
	localparam int          FIFO_WIDTH               = 8;
	localparam logic [7:0]  CMD_READ_ID              = 8'h33;
	localparam logic [2:0]  SYNC_RESET               = 3'b111;

	// one step of the shift-and-xor check register, lsb first
	function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic bit_in);
		logic fb;
		fb = crc[0] ^ bit_in;
		crc_step = (crc >> 1) ^ (fb ? CRC_POLY : CRC_RESET);
	endfunction
endpackage

// *** verilog/swid_link_if.sv ***
/*
 * the shared open-drain data wire between master and slave end.
 * assumes a pull-up: the line is low while either end enables its driver.
 */
`timescale 1ns/10ps
`default_nettype none
interface swid_link_if;
	logic master_oe;
	logic slave_oe;
	logic line;
	assign line = ~(master_oe | slave_oe);
	modport master (output master_oe, input line);
	modport slave (output slave_oe, input line);
endinterface
`default_nettype wire

// *** verilog/swid_fifo.sv ***
/*
 * small synchronous fifo with valid/ready on both sides.
 * assumes one clock for writer and reader.
 */
`timescale 1ns/10ps
`default_nettype none
module swid_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             i_mclk,
	input  wire logic             i_resetn,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ff, nxt_wr, rd_ff, nxt_rd;
	logic [AW:0]      cnt_ff, nxt_cnt;
	logic             push, pop;

	assign o_in_ready  = (cnt_ff != DEPTH[AW:0]);
	assign o_out_valid = (cnt_ff != '0);
	assign o_out_data  = mem[rd_ff];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	always_comb begin
		nxt_wr  = push ? wr_ff + 1'b1 : wr_ff;
		nxt_rd  = pop ? rd_ff + 1'b1 : rd_ff;
		nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			wr_ff  <= nxt_wr;
			rd_ff  <= nxt_rd;
			cnt_ff <= nxt_cnt;
		end
	end

	// storage has no reset: contents are only read behind a valid count
	always_ff @(posedge i_mclk) begin
		if (push) begin
			mem[wr_ff] <= i_in_data;
		end
	end
endmodule
`default_nettype wire

// *** verilog/swid_slave.sv ***
/*
 * slave end: answers a reset with presence, then receives a command byte and,
 * on the read-identity command, sends its 64-bit code lsb first.
 * assumes the link interface and a master that keeps its own timing.
 */
//
// Operation
// - hold 64-bit family, serial, check code
// - last byte is check of first 56
// - check register uses x8+x5+x4+1 feedback
// - check register starts cleared to zero
// - family lsb first, then serial bits
// - after serial bits register equals check
// - feeding check bits returns register zero
// - master reset low 480 to 960 us
// - master waits 480 us after reset
// - slave waits 15 to 60 us
// - presence low 60 to 240 us
// - presence only after valid reset
// - write one released before 15 us
// - read zero held until sample point
// - slot timer starts on falling edge
// - write zero held minimum low time
// - master allows recovery between slots
`timescale 1ns/10ps
`default_nettype none
module swid_slave #(
	parameter logic [7:0]  FAMILY_CODE = 8'h5a,
	parameter logic [47:0] SERIAL      = 48'h0123_4567_89ab,
	parameter int          RESET_CYC   = swid_pkg::RESET_LOW_CYC
) (
	input  wire logic   i_mclk,
	input  wire logic   i_resetn,
	swid_link_if.slave  link,
	output logic [63:0] o_rom_code,
	output logic        o_active
);
	typedef enum {S_IDLE, S_PWAIT, S_PLOW, S_CMD, S_SEND, S_DONE} sstate_t;

	localparam int CW = swid_pkg::CNT_W;

	// family code value is arbitrary; it is not a real maker code
	logic [55:0] data_bits;
	logic [7:0]  crc_val;
	assign data_bits = {SERIAL, FAMILY_CODE};

	// check value built by feeding the 56 data bits lsb first
	// parameters only, so this folds to a constant and costs no run-time logic
	always_comb begin
		crc_val = swid_pkg::CRC_RESET;
		for (int i = 0; i < swid_pkg::DATA_BITS; i++) begin
			crc_val = swid_pkg::crc_step(crc_val, data_bits[i]);
		end
	end

	logic [2:0]    sync_ff, nxt_sync;
	logic          line_ff, nxt_line;
	sstate_t       st_ff, nxt_st;
	logic [CW-1:0] cnt_ff, nxt_cnt;
	logic [CW-1:0] low_ff, nxt_low;
	logic [6:0]    bit_ff, nxt_bit;
	logic [7:0]    cmd_ff, nxt_cmd;
	logic          pull_ff, nxt_pull;
	logic          sampled_ff, nxt_sampled;
	logic          quiet_ff, nxt_quiet;
	logic [63:0]   rom_ff, nxt_rom;
	logic          fall, rise;

	// input conditioning: a level counts once the second and third flops agree
	always_comb begin
		nxt_sync = {sync_ff[1:0], link.line};
		nxt_line = line_ff;
		if (sync_ff[2] == sync_ff[1]) begin
			nxt_line = sync_ff[2];
		end
		// saturates, so a wire stuck low cannot wrap into a short low
		nxt_low = line_ff ? '0 : ((low_ff == '1) ? low_ff : low_ff + 1'b1);
	end
	assign fall = line_ff & ~nxt_line;
	assign rise = ~line_ff & nxt_line;

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			sync_ff <= swid_pkg::SYNC_RESET;
			line_ff <= 1'b1;
			low_ff  <= '0;
		end else begin
			sync_ff <= nxt_sync;
			line_ff <= nxt_line;
			low_ff  <= nxt_low;
		end
	end

	always_comb begin
		nxt_st      = st_ff;
		nxt_cnt     = (cnt_ff == '1) ? cnt_ff : cnt_ff + 1'b1;
		nxt_bit     = bit_ff;
		nxt_cmd     = cmd_ff;
		nxt_pull    = pull_ff;
		nxt_sampled = sampled_ff;
		nxt_quiet   = rise ? 1'b0 : quiet_ff;
		if (fall) begin
			nxt_cnt     = '0;
			nxt_sampled = 1'b0;
		end
		// our presence may outlast a short reset threshold: its end is no reset
		if (rise && !quiet_ff && (low_ff >= RESET_CYC[CW-1:0])) begin
			// a long low is a reset from any state
			nxt_st   = S_PWAIT;
			nxt_cnt  = '0;
			nxt_pull = 1'b0;
			nxt_bit  = '0;
		end else begin
			case (st_ff)
				S_IDLE: begin
					nxt_pull = 1'b0;
				end
				S_PWAIT: begin
					if (cnt_ff == CW'(swid_pkg::PRESENCE_WAIT_CYC - 1)) begin
						nxt_st   = S_PLOW;
						nxt_cnt  = '0;
						nxt_pull = 1'b1;
					end
				end
				S_PLOW: begin
					nxt_quiet = 1'b1;
					if (cnt_ff == CW'(swid_pkg::PRESENCE_LOW_CYC - 1)) begin
						nxt_st   = S_CMD;
						nxt_pull = 1'b0;
					end
				end
				// unknown commands drop to idle and stay silent until the next reset
				S_CMD: begin
					if (!sampled_ff && !fall && cnt_ff == CW'(swid_pkg::SLAVE_SAMPLE_CYC)) begin
						nxt_sampled = 1'b1;
						nxt_cmd     = {line_ff, cmd_ff[7:1]};
						nxt_bit     = bit_ff + 1'b1;
						if (bit_ff == 7'd7) begin
							nxt_bit = '0;
							nxt_st  = ({line_ff, cmd_ff[7:1]} == swid_pkg::CMD_READ_ID)
								? S_SEND : S_IDLE;
						end
					end
				end
				S_SEND: begin
					// drive only on a zero bit, hold through the master sample point
					// a one is sent by staying released, keeping the wired-and intact
					if (fall) begin
						nxt_pull = ~rom_ff[bit_ff[5:0]];
					end else if (pull_ff && cnt_ff == CW'(swid_pkg::READ_HOLD_CYC)) begin
						nxt_pull = 1'b0;
					end
					if (!sampled_ff && !fall && cnt_ff == CW'(swid_pkg::SLAVE_SAMPLE_CYC)) begin
						nxt_sampled = 1'b1;
						nxt_bit     = bit_ff + 1'b1;
						if (bit_ff == 7'(swid_pkg::ROM_BITS - 1)) begin
							nxt_st = S_DONE;
						end
					end
				end
				S_DONE: begin
					nxt_pull = 1'b0;
				end
				default: begin
					nxt_st   = S_IDLE;
					nxt_pull = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_ff      <= S_IDLE;
			cnt_ff     <= '0;
			bit_ff     <= '0;
			cmd_ff     <= '0;
			pull_ff    <= 1'b0;
			sampled_ff <= 1'b0;
			quiet_ff   <= 1'b0;
		end else begin
			st_ff      <= nxt_st;
			cnt_ff     <= nxt_cnt;
			bit_ff     <= nxt_bit;
			cmd_ff     <= nxt_cmd;
			pull_ff    <= nxt_pull;
			sampled_ff <= nxt_sampled;
			quiet_ff   <= nxt_quiet;
		end
	end

	// the code is fixed, but it leaves through a flop so o_rom_code is a register
	always_comb begin
		nxt_rom = {crc_val, data_bits};
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			rom_ff <= '0;
		end else begin
			rom_ff <= nxt_rom;
		end
	end

	assign link.slave_oe = pull_ff;
	assign o_rom_code    = rom_ff;
	assign o_active      = (st_ff == S_CMD) | (st_ff == S_SEND);
endmodule
`default_nettype wire

// *** verilog/swid_master.sv ***
/*
 * master end: on i_start issues reset, checks presence, sends the read-identity
 * command, reads 64 bits and pushes 8 bytes through a fifo to the user.
 * assumes the link interface; the user drains o_byte with valid/ready.
 */
`timescale 1ns/10ps
`default_nettype none
module swid_master #(
	parameter int RESET_CYC = swid_pkg::RESET_LOW_CYC,
	parameter int HIGH_CYC  = swid_pkg::POST_RESET_HIGH_CYC
) (
	input  wire logic       i_mclk,
	input  wire logic       i_resetn,
	swid_link_if.master     link,
	input  wire logic       i_start,
	output logic            o_busy,
	output logic            o_done,
	output logic            o_no_presence,
	output logic            o_crc_ok,
	output logic            o_byte_valid,
	input  wire logic       i_byte_ready,
	output logic [7:0]      o_byte
);
	typedef enum {M_IDLE, M_RST, M_RSTH, M_SLOT, M_PUSH, M_FIN} mstate_t;

	logic [2:0]  sync_ff, nxt_sync;
	logic        line_ff, nxt_line;
	mstate_t     st_ff, nxt_st;
	logic [15:0] cnt_ff, nxt_cnt;
	logic [6:0]  bit_ff, nxt_bit;
	logic        rd_ff, nxt_rd;
	logic        pres_ff, nxt_pres;
	logic [7:0]  sh_ff, nxt_sh;
	logic [7:0]  crc_ff, nxt_crc;
	logic        done_ff, nxt_done, nopres_ff, nxt_nopres, ok_ff, nxt_ok;
	logic        oe, wbit, push, fifo_ready;

	always_comb begin
		nxt_sync = {sync_ff[1:0], link.line};
		nxt_line = (sync_ff[2] == sync_ff[1]) ? sync_ff[2] : line_ff;
	end

	assign wbit = swid_pkg::CMD_READ_ID[bit_ff[2:0]];
	assign push = (st_ff == M_PUSH);

	always_comb begin
		nxt_st     = st_ff;
		nxt_cnt    = cnt_ff + 1'b1;
		nxt_bit    = bit_ff;
		nxt_rd     = rd_ff;
		nxt_pres   = pres_ff;
		nxt_sh     = sh_ff;
		nxt_crc    = crc_ff;
		nxt_done   = 1'b0;
		nxt_nopres = nopres_ff;
		nxt_ok     = ok_ff;
		oe         = 1'b0;
		case (st_ff)
			M_IDLE: begin
				nxt_cnt = '0;
				if (i_start) begin
					nxt_st     = M_RST;
					nxt_nopres = 1'b0;
					nxt_ok     = 1'b0;
				end
			end
			M_RST: begin
				oe = 1'b1;
				if (cnt_ff == 16'(RESET_CYC - 1)) begin
					nxt_st   = M_RSTH;
					nxt_cnt  = '0;
					nxt_pres = 1'b0;
				end
			end
			M_RSTH: begin
				if (cnt_ff == 16'(swid_pkg::MSP_CYC)) begin
					nxt_pres = ~line_ff;
				end
				if (cnt_ff == 16'(HIGH_CYC - 1)) begin
					nxt_cnt = '0;
					nxt_bit = '0;
					nxt_crc = swid_pkg::CRC_RESET;
					nxt_rd  = 1'b0;
					if (pres_ff) begin
						nxt_st = M_SLOT;
					end else begin
						nxt_st     = M_FIN;
						nxt_nopres = 1'b1;
					end
				end
			end
			M_SLOT: begin
				if (!rd_ff) begin
					oe = (cnt_ff < 16'(wbit ? swid_pkg::WRITE_ONE_LOW_CYC
						: swid_pkg::WRITE_ZERO_LOW_CYC));
				end else begin
					oe = (cnt_ff < 16'(swid_pkg::READ_LOW_CYC));
					if (cnt_ff == 16'(swid_pkg::MASTER_SAMPLE_CYC)) begin
						nxt_sh  = {line_ff, sh_ff[7:1]};
						nxt_crc = swid_pkg::crc_step(crc_ff, line_ff);
					end
				end
				if (cnt_ff == 16'(swid_pkg::SLOT_CYC + swid_pkg::RECOVERY_CYC - 1)) begin
					nxt_cnt = '0;
					nxt_bit = bit_ff + 1'b1;
					if (!rd_ff && bit_ff == 7'd7) begin
						nxt_rd  = 1'b1;
						nxt_bit = '0;
					end else if (rd_ff && bit_ff[2:0] == 3'd7) begin
						nxt_st = M_PUSH;
					end
				end
			end
			M_PUSH: begin
				// stall here until the fifo takes the byte
				nxt_cnt = '0;
				if (fifo_ready) begin
					// bit_ff has counted every read bit once the last byte leaves
					nxt_st = (bit_ff == 7'(swid_pkg::ROM_BITS)) ? M_FIN : M_SLOT;
					if (bit_ff == 7'(swid_pkg::ROM_BITS)) begin
						nxt_ok = (crc_ff == swid_pkg::CRC_RESET);
					end
				end
			end
			M_FIN: begin
				nxt_done = 1'b1;
				nxt_st   = M_IDLE;
			end
			default: begin
				nxt_st = M_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			sync_ff   <= swid_pkg::SYNC_RESET;
			line_ff   <= 1'b1;
			st_ff     <= M_IDLE;
			cnt_ff    <= '0;
			bit_ff    <= '0;
			rd_ff     <= 1'b0;
			pres_ff   <= 1'b0;
			sh_ff     <= '0;
			crc_ff    <= '0;
			done_ff   <= 1'b0;
			nopres_ff <= 1'b0;
			ok_ff     <= 1'b0;
		end else begin
			sync_ff   <= nxt_sync;
			line_ff   <= nxt_line;
			st_ff     <= nxt_st;
			cnt_ff    <= nxt_cnt;
			bit_ff    <= nxt_bit;
			rd_ff     <= nxt_rd;
			pres_ff   <= nxt_pres;
			sh_ff     <= nxt_sh;
			crc_ff    <= nxt_crc;
			done_ff   <= nxt_done;
			nopres_ff <= nxt_nopres;
			ok_ff     <= nxt_ok;
		end
	end

	assign link.master_oe = oe;
	assign o_busy         = (st_ff != M_IDLE);
	assign o_done         = done_ff;
	assign o_no_presence  = nopres_ff;
	assign o_crc_ok       = ok_ff;

	swid_fifo #(
		.WIDTH (swid_pkg::FIFO_WIDTH),
		.DEPTH (swid_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_mclk      (i_mclk),
		.i_resetn    (i_resetn),
		.i_in_valid  (push),
		.o_in_ready  (fifo_ready),
		.i_in_data   (sh_ff),
		.o_out_valid (o_byte_valid),
		.i_out_ready (i_byte_ready),
		.o_out_data  (o_byte)
	);
endmodule
`default_nettype wire

// *** bench/swid_link_assertions.sv ***
/*
 * concurrent checks on the shared wire between master and slave end.
 * assumes the count parameters equal those handed to both ends.
 */
`timescale 1ns/10ps
`default_nettype none
module swid_link_assertions #(
	parameter int M_RST  = 4000,
	parameter int S_RST  = 3500,
	parameter int M_HIGH = 8000
) (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic master_oe,
	input wire logic slave_oe,
	input wire logic line
);
	int   lo_ff, hi_ff, mon_ff, moff_ff, son_ff, fall_ff;
	logic line_q_ff, so_q_ff, mo_q_ff, rst_ff, pres_ff, mrst_ff;

	// the master idle count starts at M_HIGH so the first request after reset is not flagged
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			lo_ff <= 0;
			hi_ff <= 0;
			mon_ff <= 0;
			moff_ff <= M_HIGH;
			son_ff <= 0;
			fall_ff <= 0;
			line_q_ff <= 1'b1;
			so_q_ff <= 1'b0;
			mo_q_ff <= 1'b0;
			rst_ff <= 1'b0;
			pres_ff <= 1'b0;
			mrst_ff <= 1'b0;
		end else begin
			lo_ff <= line ? 0 : lo_ff + 1;
			hi_ff <= line ? hi_ff + 1 : 0;
			mon_ff <= master_oe ? mon_ff + 1 : 0;
			moff_ff <= master_oe ? 0 : moff_ff + 1;
			son_ff <= slave_oe ? son_ff + 1 : 0;
			fall_ff <= (line_q_ff && !line) ? 0 : fall_ff + 1;
			line_q_ff <= line;
			so_q_ff <= slave_oe;
			mo_q_ff <= master_oe;
			if (line && !line_q_ff && !so_q_ff && lo_ff >= S_RST)
				rst_ff <= 1'b1;
			else if (slave_oe && !so_q_ff && line_q_ff)
				rst_ff <= 1'b0;
			if (slave_oe && !so_q_ff && line_q_ff)
				pres_ff <= 1'b1;
			else if (!slave_oe)
				pres_ff <= 1'b0;
			if (!master_oe && mo_q_ff)
				mrst_ff <= (mon_ff >= M_RST);
		end
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);

	sequence pres_start_s;
		$rose(slave_oe) && $past(line);
	endsequence
	sequence data_start_s;
		$rose(slave_oe) && !$past(line);
	endsequence

	presence_wait_a: assert property (pres_start_s |-> hi_ff >= 750 && hi_ff <= 3000)
		else $error("presence starts outside its wait window");
	presence_cause_a: assert property (pres_start_s |-> rst_ff)
		else $error("presence without a long low before it");
	presence_len_a: assert property ($fell(slave_oe) && pres_ff |-> son_ff >= 3000 && son_ff <= 12000)
		else $error("presence low time out of range");
	zero_hold_a: assert property ($fell(slave_oe) && !pres_ff |-> fall_ff >= 750 && fall_ff <= 760)
		else $error("read zero released at the wrong time");
	slot_timer_a: assert property (data_start_s |-> fall_ff <= 8 && master_oe)
		else $error("slave drives data outside a slot start");
	wire_low_a: assert property (slave_oe |-> !line)
		else $error("line high while slave pulls it");
	master_low_a: assert property ($fell(master_oe) |-> mon_ff == 50 || mon_ff == 3000 || mon_ff == M_RST)
		else $error("master low pulse of unexpected length");
	master_gap_a: assert property ($rose(master_oe) |-> moff_ff >= (mrst_ff ? M_HIGH : 50))
		else $error("master starts too soon after release");
	quiet_master_a: assert property (slave_oe && pres_ff |-> !master_oe)
		else $error("master drives during presence");
endmodule
`default_nettype wire

// *** bench/single_wire_id_rom_slave_tb_top.sv ***
/*
 * bench: master and slave share one wire; a second slave sits on a wire
 * driven by the bench itself. assumes shortened reset counts below.
 */
`timescale 1ns/10ps
`default_nettype none
module single_wire_id_rom_slave_tb_top;
	localparam int          M_RST  = 4000;
	localparam int          S_RST  = 3500;
	localparam int          M_HIGH = 8000;
	localparam logic [7:0]  FAM    = 8'h5a;
	localparam logic [47:0] SER    = 48'h0123_4567_89ab;
	logic        i_mclk   = 1'b0;
	logic        i_resetn = 1'b0;
	logic        start    = 1'b0;
	logic        bready   = 1'b0;
	logic        m2_oe    = 1'b0;
	logic        busy, done, nop, crc_ok, bvalid, act1, act2;
	logic [7:0]  rx_byte;
	logic [63:0] rom1, rom2, exp_rom;
	logic        wire_q[$];
	int          miscompares = 0;
	int          n_checks = 0;

	swid_link_if link_a();
	swid_link_if link_b();
	assign link_b.master_oe = m2_oe;
	always #10 i_mclk = ~i_mclk;

	swid_master #(.RESET_CYC(M_RST), .HIGH_CYC(M_HIGH)) i_swid_master (.i_mclk(i_mclk),
		.i_resetn(i_resetn), .link(link_a.master), .i_start(start), .o_busy(busy),
		.o_done(done), .o_no_presence(nop), .o_crc_ok(crc_ok), .o_byte_valid(bvalid),
		.i_byte_ready(bready), .o_byte(rx_byte));
	swid_slave #(.FAMILY_CODE(FAM), .SERIAL(SER), .RESET_CYC(S_RST)) i_swid_slave (
		.i_mclk(i_mclk), .i_resetn(i_resetn), .link(link_a.slave), .o_rom_code(rom1),
		.o_active(act1));
	swid_slave #(.FAMILY_CODE(FAM), .SERIAL(SER), .RESET_CYC(S_RST)) i_swid_slave_b (
		.i_mclk(i_mclk), .i_resetn(i_resetn), .link(link_b.slave), .o_rom_code(rom2),
		.o_active(act2));
	swid_link_assertions #(.M_RST(M_RST), .S_RST(S_RST), .M_HIGH(M_HIGH))
		i_swid_link_assertions (.i_mclk(i_mclk), .i_resetn(i_resetn),
		.master_oe(link_a.master_oe), .slave_oe(link_a.slave_oe), .line(link_a.line));

	function automatic logic [7:0] crc8(input logic [63:0] d, input int n);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < n; i++)
			c = {1'b0, c[7:1]} ^ ((c[0] ^ d[i]) ? 8'h8c : 8'h00);
		return c;
	endfunction

	task automatic report_and_stop();
		if (miscompares == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask

	task automatic give_up();
		check(1'b0, "wait ran out");
		report_and_stop();
	endtask

	// one slot from the bench side: low 50 for a one or read, 3000 for a zero
	task automatic slot(input logic b, output logic s);
		for (int i = 0; i < 3100; i++) begin
			m2_oe = i < (b ? 50 : 3000);
			if (i == 700)
				s = link_b.line;
			@(negedge i_mclk);
		end
	endtask

	task automatic xfer(input logic [7:0] w, input logic [7:0] e, input logic chk);
		logic s;
		for (int i = 0; i < 8; i++) begin
			slot(w[i], s);
			if (chk)
				check(s === e[i], "read slot bit");
		end
	endtask

	task automatic bus_reset(input int n, input logic want);
		int w;
		int l;
		w = 0;
		l = 0;
		m2_oe = 1'b1;
		repeat (n) @(negedge i_mclk);
		m2_oe = 1'b0;
		while (link_b.slave_oe !== 1'b1 && w < 4000) begin
			w++;
			@(negedge i_mclk);
		end
		if (want && w == 4000)
			give_up();
		while (link_b.slave_oe === 1'b1 && l < 13000) begin
			l++;
			@(negedge i_mclk);
		end
		if (want) begin
			check(w >= 750 && w <= 3000, "presence wait");
			check(l >= 3000 && l <= 12000, "presence length");
		end else
			check(l == 0, "presence after a short low");
		repeat (8000) @(negedge i_mclk);
	endtask

	// wire bits as the master would see them, 700 cycles after each fall
	always @(negedge link_a.line) begin
		repeat (700) @(negedge i_mclk);
		wire_q.push_back(link_a.line);
	end

	initial begin
		int k;
		exp_rom = {crc8({8'h00, SER, FAM}, 56), SER, FAM};
		repeat (10) @(negedge i_mclk);
		i_resetn = 1'b1;
		repeat (100) @(negedge i_mclk);
		fork
			begin
				start = 1'b1;
				@(negedge i_mclk);
				start = 1'b0;
				check(busy === 1'b1, "master not busy");
				k = 0;
				while (done !== 1'b1 && k < 300000) begin
					k++;
					@(negedge i_mclk);
				end
				if (k == 300000)
					give_up();
				check(crc_ok === 1'b1 && nop === 1'b0, "master flags");
				check(rom1 === exp_rom, "slave code");
				check(crc8(rom1, 64) === 8'h00, "code does not close");
				@(negedge i_mclk);
				bready = 1'b1;
				for (int i = 0; i < 8; i++) begin
					check(bvalid === 1'b1 && rx_byte === exp_rom[8*i +: 8], "byte");
					@(negedge i_mclk);
				end
				bready = 1'b0;
				check(bvalid === 1'b0, "fifo not empty");
				check(wire_q.size() == 74, "wire slot count");
				for (int i = 0; i < 74; i++)
					check(wire_q[i] === (i < 2 ? 1'b0 : i < 10 ? swid_pkg::CMD_READ_ID[i-2]
						: exp_rom[i-10]), "wire bit");
			end
			begin
				bus_reset(3000, 1'b0);
				bus_reset(S_RST + 100, 1'b1);
				xfer(8'hcc, 8'h00, 1'b0);
				xfer(8'hff, 8'hff, 1'b1);
				check(act2 === 1'b0, "active after foreign command");
				bus_reset(S_RST + 100, 1'b1);
				xfer(swid_pkg::CMD_READ_ID, 8'h00, 1'b0);
				check(act2 === 1'b1, "idle after read command");
				xfer(8'hff, FAM, 1'b1);
				bus_reset(S_RST + 100, 1'b1);
				check(rom2 === exp_rom, "second slave code");
			end
		join
		report_and_stop();
	end
endmodule
`default_nettype wire
